// ===== rtl/mtseq_pkg.sv
package mtseq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Figures in milliseconds, as printed
  localparam int FIRST_DELAY_MAX_MS = 100;
  localparam int PROBE_DELAY_MIN_MS = 1;
  localparam int PROBE_DELAY_MAX_MS = 100;
  localparam int RETRY_MIN_MS = 1;
  localparam int RETRY_MAX_MS = 50;
  localparam int DONE_PULSE_MIN_MS = 1;
  localparam int DONE_PULSE_MAX_MS = 100;
  // Milliseconds field width for programmable times
  localparam int MS_W = 7;

  // ----------------------------------------------------------------
  // Judgment shift
  // ----------------------------------------------------------------
  localparam int SHIFT_MAX = 99;
  localparam int SHIFT_W = 7;
  localparam int SHIFT_DEPTH = 128;

  // ----------------------------------------------------------------
  // Settings compare
  // ----------------------------------------------------------------
  localparam logic [13:0] TOL_MAX = 14'h270F;  // 9.999 relative_output in 0.001 steps
  localparam logic [1:0] ORDER_FIRST = 2'h1;
  localparam logic [1:0] ORDER_SECOND = 2'h2;
  localparam logic [1:0] ORDER_RST = 2'h1;

  // ----------------------------------------------------------------
  // Identity
  // ----------------------------------------------------------------
  localparam logic [35:0] SERIAL_DEFAULT = 36'h000000001;  // Arbitrary value

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_DELAY = 3'h2,
    ST_MEAS = 3'h3,
    ST_RETRY = 3'h4
  } mtseq_state_t;

  // Judgment codes
  typedef enum logic [1:0] {
    JUD_PASS = 2'h0,
    JUD_HIGH = 2'h1,
    JUD_LOW = 2'h2,
    JUD_ERR = 2'h3
  } mtseq_jud_t;

endpackage

// ===== rtl/mtseq_shift_if.sv
`timescale 1ns/100ps
`default_nettype none
// Link between sequencer and judgment delay memory
interface mtseq_shift_if;
  logic wrEn;
  logic [6:0] wrAddr;
  logic [3:0] wrData;
  logic [6:0] rdAddr;
  logic [3:0] rdData;
  logic clear;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, output clear,
    input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, input clear,
    output rdData);
endinterface
`default_nettype wire

// ===== rtl/mtseq_shift_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mtseq_shift_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 4
) (
  // Clock
  input wire logic clk,
  // Port
  mtseq_shift_if.mem port
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] validFf;
  logic [WIDTH-1:0] rdFf;

  // Elaboration check: the link carries 7-bit addresses and 4-bit words
  if (DEPTH != 128 || WIDTH != 4)
  begin : g_size_check
    $error("mtseq_shift_mem supports DEPTH 128 and WIDTH 4 only");
  end

  // Storage with per-slot valid, clear empties all slots
  always_ff @(posedge clk)
  begin
    if (port.wrEn)
    begin
      mem[port.wrAddr] <= port.wrData;
    end
    if (port.clear)
    begin
      validFf <= '0;
    end
    else if (port.wrEn)
    begin
      validFf[port.wrAddr] <= 1'b1;
    end
    rdFf <= validFf[port.rdAddr] ? mem[port.rdAddr] : '0;
  end

  assign port.rdData = rdFf;

endmodule
`default_nettype wire

// ===== rtl/mtseq_top.sv
`timescale 1ns/100ps
`default_nettype none
module mtseq_top #(
  parameter logic [35:0] SERIAL = mtseq_pkg::SERIAL_DEFAULT,
  parameter int CYC_MS = mtseq_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands, one-cycle pulses
  input wire logic cmdInitiate,
  input wire logic cmdLocal,
  input wire logic cmdRemote,
  input wire logic cmdShiftClear,
  input wire logic cmdSysReset,
  input wire logic cmdSetCont,
  input wire logic cmdSetSource,
  input wire logic cmdSetShift,
  input wire logic cmdSetTimes,
  input wire logic cmdSetOpts,
  // Command data
  input wire logic setContinuous,
  input wire logic setExtSource,
  input wire logic [6:0] setPassShift,
  input wire logic [6:0] setHighLowShift,
  input wire logic [6:0] setErrShift,
  input wire logic [6:0] setFirstDelayMs,
  input wire logic [6:0] setProbeDelayMs,
  input wire logic [6:0] setRetryMs,
  input wire logic [6:0] setDonePulseMs,
  input wire logic setShiftEn,
  input wire logic setProbeCheckEn,
  input wire logic setRetryEn,
  input wire logic setAutoSend,
  input wire logic setBinary,
  input wire logic setRelative,
  input wire logic setFallEdge,
  input wire logic setDonePulse,
  input wire logic setCompareEn,
  input wire logic [1:0] setCompareOrder,
  input wire logic [13:0] setTolerance,
  input wire logic parallelBus,
  // External trigger pin, edge chosen by setFallEdge (falling after reset)
  input wire logic extTriggerIn,
  // Measurement engine
  output logic measStart,
  input wire logic measDone,
  input wire logic measFail,
  input wire logic [1:0] measJudgment,
  // Status and outputs
  output logic execError,
  output logic remoteOn,
  output logic keysEnabled,
  output logic continuousRun,
  output logic autoMemoryOff,
  output logic measureDoneOut,
  output logic probeShortCheck,
  output logic valueSend,
  output logic sendTerminator,
  output logic relativeOutput,
  output logic saveSettings,
  output logic [3:0] judgmentOut,
  output logic [35:0] serialNumber,
  output logic compareEn,
  output logic [1:0] compareOrder,
  output logic [13:0] compareTolerance,
  output logic [2:0] seqState
);

  // Elaboration check: a millisecond is at least one cycle, 100 ms fits the timers
  if (CYC_MS < 1 || CYC_MS > 167772)
  begin : g_cyc_check
    $error("CYC_MS out of range");
  end

  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Clip a count to its minimum and maximum
  function automatic logic [6:0] clip(input logic [6:0] v, input logic [6:0] lo,
    input logic [6:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pinSync;
    logic pinStable;
    mtseq_pkg::mtseq_state_t state;
    logic [23:0] timer;
    logic [23:0] doneTimer;
    logic [23:0] probeTimer;
    logic probeArm;
    logic probeFire;
    logic start;
    logic err;
    logic remote;
    logic cont;
    logic extSrc;
    logic autoMemOff;
    logic [6:0] passShift;
    logic [6:0] hlShift;
    logic [6:0] errShift;
    logic [6:0] firstMs;
    logic [6:0] probeMs;
    logic [6:0] retryMs;
    logic [6:0] pulseMs;
    logic shiftEn;
    logic probeEn;
    logic retryEn;
    logic autoSend;
    logic binary;
    logic relative;
    logic fallEdge;
    logic donePulse;
    logic cmpEn;
    logic [1:0] cmpOrder;
    logic [13:0] tol;
    logic doneOut;
    logic send;
    logic pinTrig;
    logic save;
    logic [6:0] wrPtr;
    logic [3:0] judge;
    logic judgeLoad;
    logic [1:0] judgeKind;
    logic judgeNow;
  } mtseq_regs_t;

  mtseq_regs_t cur_ff;
  mtseq_regs_t nxt_cur;

  mtseq_shift_if shiftBus ();

  mtseq_shift_mem #(
    .DEPTH(mtseq_pkg::SHIFT_DEPTH),
    .WIDTH(4)
  ) u_mem (
    .clk(clk),
    .port(shiftBus)
  );

  logic trigEdge;
  logic [23:0] msCycles;
  logic [6:0] kindShift;
  logic [3:0] judgeCode;
  logic resultWr;

  // Trigger edge from the agreeing pair of synchroniser stages
  assign trigEdge = (cur_ff.pinSync[1] == cur_ff.pinSync[2])
    && (cur_ff.pinSync[2] != cur_ff.pinStable)
    && (cur_ff.pinSync[2] == ~cur_ff.fallEdge);
  assign msCycles = 24'(CYC_MS);
  assign judgeCode = 4'h1 << measJudgment;
  assign kindShift = (measJudgment == mtseq_pkg::JUD_PASS) ? cur_ff.passShift :
    (measJudgment == mtseq_pkg::JUD_ERR) ? cur_ff.errShift : cur_ff.hlShift;

  // Judgment lands ahead by its shift; other cycles empty the slot just consumed
  assign resultWr = measDone && !measFail && cur_ff.state == mtseq_pkg::ST_MEAS
    && cur_ff.shiftEn && kindShift != 7'h00;
  assign shiftBus.wrEn = 1'b1;
  assign shiftBus.wrAddr = resultWr ? 7'(cur_ff.wrPtr + kindShift)
    : 7'(cur_ff.wrPtr - 7'h1);
  assign shiftBus.wrData = resultWr ? judgeCode : 4'h0;
  assign shiftBus.rdAddr = cur_ff.wrPtr;
  // Slots also emptied while held in reset, so nothing stale is shown
  assign shiftBus.clear = cmdShiftClear || cmdSysReset || !rstN;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.pinSync = {cur_ff.pinSync[1:0], extTriggerIn};
    if (cur_ff.pinSync[1] == cur_ff.pinSync[2])
    begin
      nxt_cur.pinStable = cur_ff.pinSync[2];
    end
    nxt_cur.start = 1'b0;
    nxt_cur.err = 1'b0;
    nxt_cur.send = 1'b0;
    nxt_cur.save = 1'b0;
    nxt_cur.probeFire = 1'b0;
    nxt_cur.judgeLoad = 1'b0;
    nxt_cur.pinTrig = 1'b0;

    // Remote / local
    if (cmdRemote)
    begin
      nxt_cur.remote = 1'b1;
    end
    if (cmdLocal)
    begin
      nxt_cur.remote = 1'b0;
      nxt_cur.cont = 1'b1;
    end

    // Settings
    if (cmdSetCont && cur_ff.remote && !cmdLocal)
    begin
      nxt_cur.cont = setContinuous;
    end
    if (cmdSetSource)
    begin
      nxt_cur.extSrc = setExtSource;
      if (setExtSource)
      begin
        nxt_cur.autoMemOff = 1'b1;
      end
    end
    if (cmdSetShift)
    begin
      nxt_cur.passShift = clip(setPassShift, 7'h00, 7'(mtseq_pkg::SHIFT_MAX));
      nxt_cur.hlShift = clip(setHighLowShift, 7'h00, 7'(mtseq_pkg::SHIFT_MAX));
      nxt_cur.errShift = clip(setErrShift, 7'h00, 7'(mtseq_pkg::SHIFT_MAX));
    end
    if (cmdSetTimes)
    begin
      nxt_cur.firstMs = clip(setFirstDelayMs, 7'h00,
        7'(mtseq_pkg::FIRST_DELAY_MAX_MS));
      nxt_cur.probeMs = clip(setProbeDelayMs, 7'(mtseq_pkg::PROBE_DELAY_MIN_MS),
        7'(mtseq_pkg::PROBE_DELAY_MAX_MS));
      nxt_cur.retryMs = clip(setRetryMs, 7'(mtseq_pkg::RETRY_MIN_MS),
        7'(mtseq_pkg::RETRY_MAX_MS));
      nxt_cur.pulseMs = clip(setDonePulseMs, 7'(mtseq_pkg::DONE_PULSE_MIN_MS),
        7'(mtseq_pkg::DONE_PULSE_MAX_MS));
    end
    if (cmdSetOpts)
    begin
      nxt_cur.shiftEn = setShiftEn;
      nxt_cur.probeEn = setProbeCheckEn;
      nxt_cur.retryEn = setRetryEn;
      nxt_cur.autoSend = setAutoSend && !parallelBus;
      nxt_cur.binary = setBinary;
      nxt_cur.relative = setRelative;
      nxt_cur.fallEdge = setFallEdge;
      nxt_cur.donePulse = setDonePulse;
      nxt_cur.cmpEn = setCompareEn;
      if (setCompareOrder == mtseq_pkg::ORDER_FIRST || setCompareOrder == mtseq_pkg::ORDER_SECOND)
      begin
        nxt_cur.cmpOrder = setCompareOrder;
      end
      nxt_cur.tol = (setTolerance > mtseq_pkg::TOL_MAX) ? mtseq_pkg::TOL_MAX : setTolerance;
    end
    if (cmdShiftClear)
    begin
      nxt_cur.judge = 4'h0;
    end

    // Sequencer
    case (cur_ff.state)
      mtseq_pkg::ST_IDLE:
      begin
        if (cmdInitiate && !cur_ff.cont)
        begin
          nxt_cur.state = mtseq_pkg::ST_WAIT;
        end
        else if (cur_ff.cont)
        begin
          nxt_cur.state = mtseq_pkg::ST_WAIT;
        end
      end
      mtseq_pkg::ST_WAIT:
      begin
        if (!cur_ff.extSrc || trigEdge)
        begin
          nxt_cur.state = mtseq_pkg::ST_DELAY;
          nxt_cur.timer = 24'(cur_ff.firstMs * msCycles);
          nxt_cur.pinTrig = trigEdge;
        end
      end
      mtseq_pkg::ST_DELAY, mtseq_pkg::ST_RETRY:
      begin
        if (cur_ff.timer == 24'h0)
        begin
          nxt_cur.state = mtseq_pkg::ST_MEAS;
          nxt_cur.start = 1'b1;
          nxt_cur.doneOut = 1'b0;
        end
        else
        begin
          nxt_cur.timer = cur_ff.timer - 24'h1;
        end
      end
      mtseq_pkg::ST_MEAS:
      begin
        // Triggers are not looked at here and are dropped
        if (measDone)
        begin
          if (measFail && cur_ff.retryEn)
          begin
            nxt_cur.state = mtseq_pkg::ST_RETRY;
            nxt_cur.timer = 24'(cur_ff.retryMs * msCycles - 24'h1);
          end
          else
          begin
            nxt_cur.state = cur_ff.cont ? mtseq_pkg::ST_WAIT : mtseq_pkg::ST_IDLE;
            nxt_cur.doneOut = 1'b1;
            nxt_cur.doneTimer = 24'(cur_ff.pulseMs * msCycles - 24'h1);
            nxt_cur.send = cur_ff.autoSend && cur_ff.extSrc && !parallelBus;
            nxt_cur.wrPtr = 7'(cur_ff.wrPtr + 7'h1);
            nxt_cur.judgeLoad = 1'b1;
            nxt_cur.judgeKind = measJudgment;
            nxt_cur.judgeNow = (kindShift == 7'h00);
            if (cur_ff.probeEn)
            begin
              nxt_cur.probeArm = 1'b1;
              nxt_cur.probeTimer = 24'(cur_ff.probeMs * msCycles - 24'h1);
            end
          end
        end
      end
      default:
      begin
        nxt_cur.state = mtseq_pkg::ST_IDLE;
      end
    endcase

    // Under internal source a pin edge sends the latest value
    if (trigEdge && !cur_ff.extSrc && cur_ff.autoSend && !parallelBus)
    begin
      nxt_cur.send = 1'b1;
    end

    if (cmdInitiate && cur_ff.cont)
    begin
      nxt_cur.err = 1'b1;
    end

    // Judgment output update, one cycle after completion
    if (cur_ff.judgeLoad && !cmdShiftClear)
    begin
      nxt_cur.judge = (4'h1 << cur_ff.judgeKind);
      if (cur_ff.shiftEn)
      begin
        // Zero shift bypasses the memory and joins what is due now
        nxt_cur.judge = shiftBus.rdData | (cur_ff.judgeNow ? (4'h1 << cur_ff.judgeKind) : 4'h0);
      end
    end

    // Done pulse width
    if (cur_ff.doneOut && cur_ff.donePulse && !(cur_ff.state == mtseq_pkg::ST_MEAS && measDone))
    begin
      if (cur_ff.doneTimer == 24'h0)
      begin
        nxt_cur.doneOut = 1'b0;
      end
      else
      begin
        nxt_cur.doneTimer = cur_ff.doneTimer - 24'h1;
      end
    end

    // Probe short check timer
    if (cur_ff.probeArm && !(cur_ff.state == mtseq_pkg::ST_MEAS && measDone))
    begin
      if (cur_ff.probeTimer == 24'h0)
      begin
        nxt_cur.probeArm = 1'b0;
        nxt_cur.probeFire = 1'b1;
      end
      else
      begin
        nxt_cur.probeTimer = cur_ff.probeTimer - 24'h1;
      end
    end

    // System reset: defaults except communication and autoMemOff, save pulsed in the same cycle
    if (cmdSysReset)
    begin
      nxt_cur.state = mtseq_pkg::ST_IDLE;
      nxt_cur.cont = 1'b1;
      nxt_cur.extSrc = 1'b0;
      nxt_cur.passShift = 7'h00;
      nxt_cur.hlShift = 7'h00;
      nxt_cur.errShift = 7'h00;
      nxt_cur.firstMs = 7'h00;
      nxt_cur.probeMs = 7'h01;
      nxt_cur.retryMs = 7'h01;
      nxt_cur.pulseMs = 7'h01;
      nxt_cur.shiftEn = 1'b0;
      nxt_cur.probeEn = 1'b0;
      nxt_cur.retryEn = 1'b0;
      nxt_cur.relative = 1'b0;
      nxt_cur.fallEdge = 1'b1;
      nxt_cur.donePulse = 1'b0;
      nxt_cur.cmpEn = 1'b0;
      nxt_cur.cmpOrder = mtseq_pkg::ORDER_RST;
      nxt_cur.tol = 14'h0000;
      nxt_cur.judge = 4'h0;
      nxt_cur.probeArm = 1'b0;
      nxt_cur.save = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cur_ff <= '0;
      cur_ff.pinSync <= 3'h7;
      cur_ff.pinStable <= 1'b1;
      cur_ff.cont <= 1'b1;
      cur_ff.fallEdge <= 1'b1;
      cur_ff.probeMs <= 7'h01;
      cur_ff.retryMs <= 7'h01;
      cur_ff.pulseMs <= 7'h01;
      cur_ff.cmpOrder <= mtseq_pkg::ORDER_RST;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs
  assign measStart = cur_ff.start;
  assign execError = cur_ff.err;
  assign remoteOn = cur_ff.remote;
  assign keysEnabled = !cur_ff.remote;
  assign continuousRun = cur_ff.cont;
  assign autoMemoryOff = cur_ff.autoMemOff;
  assign measureDoneOut = cur_ff.doneOut;
  assign probeShortCheck = cur_ff.probeFire;
  assign valueSend = cur_ff.send;
  assign sendTerminator = cur_ff.send && !cur_ff.binary;
  assign relativeOutput = cur_ff.relative;
  assign saveSettings = cur_ff.save;
  assign judgmentOut = cur_ff.judge;
  assign serialNumber = SERIAL;
  assign compareEn = cur_ff.cmpEn;
  assign compareOrder = cur_ff.cmpOrder;
  assign compareTolerance = cur_ff.tol;
  assign seqState = cur_ff.state;

endmodule
`default_nettype wire

// ===== test/mtseq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mtseq_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands and levels
  input wire logic cmdInitiate,
  input wire logic cmdLocal,
  input wire logic cmdSetCont,
  input wire logic cmdSysReset,
  input wire logic parallelBus,
  // Engine
  input wire logic measDone,
  input wire logic measFail,
  // Status
  input wire logic execError,
  input wire logic remoteOn,
  input wire logic keysEnabled,
  input wire logic continuousRun,
  input wire logic measureDoneOut,
  input wire logic valueSend,
  input wire logic [2:0] seqState
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Good end of a measurement
  sequence s_good_end;
    measDone && !measFail && seqState == mtseq_pkg::ST_MEAS;
  endsequence
  // Local state after leaving remote
  sequence s_local_state;
    !remoteOn && keysEnabled && continuousRun;
  endsequence
  a_init_cont_error:
    assert property (cmdInitiate && continuousRun |=> execError)
    else $error("initiate while continuous not flagged");
  a_cont_rearm:
    assert property (s_good_end ##0 continuousRun |=> seqState != mtseq_pkg::ST_IDLE)
    else $error("continuous run stopped");
  a_single_idle:
    assert property (s_good_end ##0 !continuousRun |=> seqState == mtseq_pkg::ST_IDLE)
    else $error("single run did not go idle");
  a_idle_stays:
    assert property (seqState == mtseq_pkg::ST_IDLE && !cmdInitiate && !continuousRun
      && !cmdSetCont && !cmdLocal && !cmdSysReset |=> seqState == mtseq_pkg::ST_IDLE)
    else $error("idle left without initiate");
  a_arm_from_idle:
    assert property (seqState == mtseq_pkg::ST_IDLE && cmdInitiate && !continuousRun
      |=> seqState == mtseq_pkg::ST_WAIT)
    else $error("initiate did not arm");
  a_local_restores:
    assert property (cmdLocal |=> s_local_state)
    else $error("local did not restore panel and continuous");
  a_done_cause:
    assert property ($rose(measureDoneOut) |-> $past(measDone))
    else $error("done output rose without a finish");
  a_par_no_send:
    assert property (parallelBus && $past(parallelBus) |-> !valueSend)
    else $error("value sent on parallel bus");
endmodule
`default_nettype wire

// ===== test/mtseq_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module mtseq_engine_model (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic failNext,
  input wire logic [1:0] judIn,
  input wire logic [7:0] latency,
  // Engine handshake
  input wire logic measStart,
  output logic measDone,
  output logic measFail,
  output logic [1:0] measJudgment
);
  // Quiet outputs at time zero
  initial
  begin
    measDone = 1'b0;
    measFail = 1'b0;
    measJudgment = 2'h0;
  end
  // Finishes each start after the latency; judgment line inverted between results
  always @(posedge clk)
  begin
    if (measStart === 1'b1)
    begin
      repeat (latency) @(posedge clk);
      #2;
      measDone = 1'b1;
      measFail = failNext;
      measJudgment = judIn;
      @(posedge clk);
      #2;
      measDone = 1'b0;
      measFail = 1'b0;
      measJudgment = ~judIn;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int CYC = 10;
  localparam logic [35:0] SER = 36'h123454321;  // Arbitrary value
  localparam int PRB = 0, STA = 1, SND = 2, TRM = 3, SAV = 4, ERR = 5, DON = 6, NDN = 7, FLR = 8;
  logic clk = 1'b0, rst_n = 1'b0, failNext = 1'b0, extTriggerIn = 1'b1, parallelBus = 1'b0;
  logic setContinuous = 1'b1, setExtSource = 1'b0, setShiftEn = 1'b0, setProbeCheckEn = 1'b0;
  logic setRetryEn = 1'b0, setAutoSend = 1'b1, setBinary = 1'b0, setRelative = 1'b0;
  logic setFallEdge = 1'b1, setDonePulse = 1'b1, setCompareEn = 1'b0;
  logic [1:0] setCompareOrder = 2'h1, judIn = 2'h0, measJudgment, compareOrder;
  logic [6:0] sh = 7'h02, setFirstDelayMs = 7'h02, setProbeDelayMs = 7'h01;
  logic [6:0] setRetryMs = 7'h01, setDonePulseMs = 7'h01;
  logic [7:0] lat = 8'h05;
  logic [9:0] cmd = 10'h000;
  logic [13:0] setTolerance = 14'h3FFF, compareTolerance;
  logic measStart, measDone, measFail, execError, remoteOn, keysEnabled, continuousRun;
  logic autoMemoryOff, measureDoneOut, probeShortCheck, valueSend, sendTerminator;
  logic relativeOutput, saveSettings, compareEn;
  logic [3:0] judgmentOut;
  logic [35:0] serialNumber;
  logic [2:0] seqState;
  logic [8:0] ev;
  logic [3:0] expQ[$];
  logic [1:0] hist[$];
  int cnt[9];
  int n_fail = 0, checks_done = 0, n, s, i;
  mtseq_top #(.SERIAL(SER), .CYC_MS(CYC)) dut (
    .clk, .rst_n, .cmdInitiate(cmd[0]), .cmdLocal(cmd[1]), .cmdRemote(cmd[2]),
    .cmdShiftClear(cmd[3]), .cmdSysReset(cmd[4]), .cmdSetCont(cmd[5]), .cmdSetSource(cmd[6]),
    .cmdSetShift(cmd[7]), .cmdSetTimes(cmd[8]), .cmdSetOpts(cmd[9]), .setContinuous,
    .setExtSource, .setPassShift(sh), .setHighLowShift(sh), .setErrShift(sh), .setFirstDelayMs,
    .setProbeDelayMs, .setRetryMs, .setDonePulseMs, .setShiftEn, .setProbeCheckEn, .setRetryEn,
    .setAutoSend, .setBinary, .setRelative, .setFallEdge, .setDonePulse, .setCompareEn,
    .setCompareOrder, .setTolerance, .parallelBus, .extTriggerIn, .measStart, .measDone,
    .measFail, .measJudgment, .execError, .remoteOn, .keysEnabled, .continuousRun,
    .autoMemoryOff, .measureDoneOut, .probeShortCheck, .valueSend, .sendTerminator,
    .relativeOutput, .saveSettings, .judgmentOut, .serialNumber, .compareEn, .compareOrder,
    .compareTolerance, .seqState);
  mtseq_engine_model eng (.clk, .failNext, .judIn, .latency(lat), .measStart, .measDone,
    .measFail, .measJudgment);
  // Clock and event vector
  always #5 clk = ~clk;
  assign ev = {measFail, !measureDoneOut, measureDoneOut, execError, saveSettings,
    sendTerminator, valueSend, measStart, probeShortCheck};
  // Counts events per edge
  always @(posedge clk)
  begin
    for (int k = 0; k < 9; k++)
      if (ev[k] === 1'b1)
        cnt[k]++;
  end
  // Compares shown judgment with oldest note
  always @(posedge clk)
  begin
    if (measDone === 1'b1 && expQ.size() > 0)
    begin
      repeat (2) @(posedge clk);
      #1;
      check({32'h0, judgmentOut}, {32'h0, expQ.pop_front()});
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic pulse(input int k);
    tick(1);
    cmd[k] = 1'b1;
    tick(1);
    cmd[k] = 1'b0;
  endtask
  task automatic ext_trigger_in;
    extTriggerIn = 1'b0;
    tick(5);
    extTriggerIn = 1'b1;
  endtask
  task automatic wait_ev(input int b, output int c);
    c = 0;
    do
    begin
      tick(1);
      c++;
    end while (ev[b] !== 1'b1 && c < 3000);
    if (ev[b] !== 1'b1)
      n_fail++;
  endtask
  task automatic close_out;
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    s = $urandom(32'hC943);
    tick(2);
    rst_n = 1'b1;
    tick(3);
    check(36'(continuousRun), 36'h1);
    check(serialNumber, SER);
    pulse(0);
    tick(2);
    check(36'(cnt[ERR]), 36'h1);
    pulse(2);
    setContinuous = 1'b0;
    pulse(5);
    tick(40);
    check(36'(seqState), 36'(mtseq_pkg::ST_IDLE));
    s = cnt[STA];
    ext_trigger_in();
    tick(40);
    check(36'(cnt[STA]), 36'(s));
    pulse(8);
    {setShiftEn, setProbeCheckEn, setRetryEn, setRelative} = 4'hF;
    setCompareEn = 1'b1;
    setCompareOrder = 2'h2;
    pulse(9);
    pulse(7);
    tick(2);
    check({compareEn, compareOrder, compareTolerance}, {1'b1, 2'h2, mtseq_pkg::TOL_MAX});
    check(36'(relativeOutput), 36'h1);
    for (i = 0; i < 6; i++)
    begin
      judIn = 2'($urandom());
      hist.push_back(judIn);
      expQ.push_back(i < 2 ? 4'h0 : 4'h1 << hist[i - 2]);
      pulse(0);
      wait_ev(STA, n);
      if (i == 0)
        check(36'(n), 36'(setFirstDelayMs * CYC + 2));
      wait_ev(PRB, n);
      check(36'((n - lat - setProbeDelayMs * CYC) inside {[2:3]}), 36'h1);
      tick(30);
    end
    pulse(3);
    expQ.push_back(4'h0);
    pulse(0);
    wait_ev(DON, n);
    wait_ev(NDN, n);
    check(36'(n), 36'(CYC));
    tick(30);
    setShiftEn = 1'b0;
    pulse(9);
    judIn = 2'h3;
    expQ.push_back(4'h8);
    pulse(0);
    tick(60);
    failNext = 1'b1;
    pulse(0);
    wait_ev(FLR, n);
    failNext = 1'b0;
    wait_ev(STA, n);
    check(36'(n inside {[CYC:CYC + 2]}), 36'h1);
    tick(60);
    setExtSource = 1'b1;
    pulse(6);
    tick(1);
    check(36'(autoMemoryOff), 36'h1);
    lat = 8'h28;
    s = cnt[STA];
    i = cnt[SND];
    n = cnt[TRM];
    pulse(0);
    tick(40);
    check(36'(cnt[STA]), 36'(s));
    ext_trigger_in();
    tick(40);
    ext_trigger_in();
    tick(60);
    check(36'(cnt[STA]), 36'(s + 1));
    check(36'(seqState), 36'(mtseq_pkg::ST_IDLE));
    check(36'(cnt[SND] - i), 36'h1);
    check(36'(cnt[TRM] - n), 36'h1);
    setBinary = 1'b1;
    pulse(9);
    pulse(0);
    ext_trigger_in();
    tick(100);
    check(36'(cnt[TRM] - n), 36'h1);
    setFallEdge = 1'b0;
    parallelBus = 1'b1;
    pulse(9);
    pulse(0);
    extTriggerIn = 1'b0;
    tick(40);
    check(36'(cnt[STA]), 36'(s + 2));
    extTriggerIn = 1'b1;
    tick(100);
    check(36'(cnt[STA]), 36'(s + 3));
    check(36'(cnt[SND] - i), 36'h2);
    parallelBus = 1'b0;
    lat = 8'h05;
    pulse(1);
    tick(2);
    check({35'h0, continuousRun & keysEnabled}, 36'h1);
    s = cnt[SAV];
    pulse(4);
    tick(2);
    check(36'(cnt[SAV] - s), 36'h1);
    check(36'(relativeOutput), 36'h0);
    s = cnt[STA];
    tick(200);
    check(36'(cnt[STA] > s + 3), 36'h1);
    close_out();
  end
  // Cuts a hung run short
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
bind mtseq_top mtseq_monitor mon (.clk, .rst_n, .cmdInitiate, .cmdLocal, .cmdSetCont,
  .cmdSysReset, .parallelBus, .measDone, .measFail, .execError, .remoteOn, .keysEnabled,
  .continuousRun, .measureDoneOut, .valueSend, .seqState);
`default_nettype wire
